// ---- verilog/qio_ports.sv ----
// four 8-bit ports, quasi-bidirectional except open-drain port zero, with bus and alternate functions
`include "qio_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module qio_ports
#(
	parameter int NPORT = 4,
	parameter int W     = 8
)
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output var  logic [31:0]             prdata,
	output var  logic                    pready,
	output var  logic                    pslverr,
	input  wire logic                    ext_active,
	input  wire logic                    ext_wide,
	input  wire logic [15:0]             ext_addr,
	input  wire logic [7:0]              ext_wdata,
	input  wire qio_pkg::qio_bus_phase_t ext_phase,
	input  wire logic                    ext_rd_sample,
	output var  logic [7:0]              ext_rdata,
	input  wire logic [7:0]              alt_out,
	output var  logic                    rxd_in,
	output var  logic                    ext_irq_zero_n,
	output var  logic                    ext_irq_one_n,
	output var  logic                    counter_zero_ext_input,
	output var  logic                    counter_one_ext_input,
	output var  logic                    cycle_start,
	input  wire logic [7:0]              p0_i,
	output var  logic [7:0]              p0_o,
	output var  logic [7:0]              p0_oe,
	input  wire logic [7:0]              p1_i,
	output var  logic [7:0]              p1_o,
	output var  logic [7:0]              p1_oe,
	input  wire logic [7:0]              p2_i,
	output var  logic [7:0]              p2_o,
	output var  logic [7:0]              p2_oe,
	input  wire logic [7:0]              p3_i,
	output var  logic [7:0]              p3_o,
	output var  logic [7:0]              p3_oe
);
	import qio_pkg::*;

	////////////////////////////////////////////////////////////////////
	// functions

	// bit operation on a latch byte; all 8 bits come back
	function automatic logic [W-1:0] rmw_bit
	(
		input logic [W-1:0] cur,
		input logic [2:0]   sel,
		input qio_bitop_t   op
	);
		logic [W-1:0] res;
		res = cur;
		case (op)
			QIO_OP_SET:   res[sel] = 1'b1;
			QIO_OP_CLEAR: res[sel] = 1'b0;
			QIO_OP_CPL:   res[sel] = ~cur[sel];
			default:      res = cur;
		endcase
		return res;
	endfunction

	// quasi-bidirectional drive: 0 pulls down, 1 drives high only while its strong pull-up bit is set
	function automatic logic [W-1:0] quasi_oe
	(
		input logic [W-1:0] val,
		input logic [W-1:0] spu
	);
		return ~val | (val & spu);
	endfunction

	////////////////////////////////////////////////////////////////////
	// declarations

	logic [W-1:0] latch_r     [NPORT];
	logic [W-1:0] buf_r       [NPORT];
	logic [W-1:0] sync1_r     [NPORT];
	logic [W-1:0] sync2_r     [NPORT];
	logic [W-1:0] sync3_r     [NPORT];
	logic [W-1:0] pin_r       [NPORT];
	logic [W-1:0] pin_raw     [NPORT];
	logic [W-1:0] eff_r       [NPORT];
	logic [W-1:0] eff_nxt     [NPORT];
	logic [W-1:0] drv_o_r     [NPORT];
	logic [W-1:0] drv_oe_r    [NPORT];
	logic [W-1:0] spu_r       [NPORT];
	qio_state_t   state_r;
	qio_state_t   state_nxt;
	logic         ph2_r;
	logic         ph1;
	logic         s1p1;
	logic         setup;
	logic         access;
	logic         mapped;
	logic [31:0]  rdata_nxt;
	logic [7:0]   ext_rdata_r;
	logic         p0_bus;
	logic         p2_bus;
	qio_bitop_t   bitop;
	logic [1:0]   bitport;
	logic [2:0]   bitsel;

	assign pin_raw[0] = p0_i;
	assign pin_raw[1] = p1_i;
	assign pin_raw[2] = p2_i;
	assign pin_raw[3] = p3_i;

	////////////////////////////////////////////////////////////////////
	// machine-cycle timing: a state is two clocks, phase 1 then phase 2

	assign ph1  = ~ph2_r;
	assign s1p1 = ph1 && (state_r == QIO_S1);

	always_comb
	begin
		case (state_r)
			QIO_S1:  state_nxt = QIO_S2;
			QIO_S2:  state_nxt = QIO_S3;
			QIO_S3:  state_nxt = QIO_S4;
			QIO_S4:  state_nxt = QIO_S5;
			QIO_S5:  state_nxt = QIO_S6;
			QIO_S6:  state_nxt = QIO_S1;
			default: state_nxt = QIO_S1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ph2_r   <= 1'b0;
			state_r <= QIO_S1;
		end
		else
		begin
			ph2_r <= ~ph2_r;
			if (ph2_r)
				state_r <= state_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cycle_start <= 1'b0;
		else
			cycle_start <= ph2_r && (state_r == QIO_S6);
	end

	////////////////////////////////////////////////////////////////////
	// pin input buffers: three flops, accept once stages two and three agree

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NPORT; p++)
			begin
				sync1_r[p] <= `QIO_LATCH_RST;
				sync2_r[p] <= `QIO_LATCH_RST;
				sync3_r[p] <= `QIO_LATCH_RST;
				pin_r[p]   <= `QIO_LATCH_RST;
			end
		end
		else
		begin
			for (int p = 0; p < NPORT; p++)
			begin
				sync1_r[p] <= pin_raw[p];
				sync2_r[p] <= sync1_r[p];
				sync3_r[p] <= sync2_r[p];
				for (int b = 0; b < W; b++)
					if (sync2_r[p][b] == sync3_r[p][b])
						pin_r[p][b] <= sync2_r[p][b];
			end
		end
	end

	// alternate inputs see the pin whatever the latch holds
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rxd_in                 <= 1'b1;
			ext_irq_zero_n         <= 1'b1;
			ext_irq_one_n          <= 1'b1;
			counter_zero_ext_input <= 1'b1;
			counter_one_ext_input  <= 1'b1;
		end
		else
		begin
			rxd_in                 <= pin_r[3][0];
			ext_irq_zero_n         <= pin_r[3][2];
			ext_irq_one_n          <= pin_r[3][3];
			counter_zero_ext_input <= pin_r[3][4];
			counter_one_ext_input  <= pin_r[3][5];
		end
	end

	// read data from external memory comes in through port zero pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ext_rdata_r <= 8'h00;
		else if (ext_active && ext_rd_sample)
			ext_rdata_r <= pin_r[0];
	end

	assign ext_rdata = ext_rdata_r;

	////////////////////////////////////////////////////////////////////
	// register bus: decode in setup, answer in the access phase

	assign setup   = psel && !penable;
	assign access  = psel && penable && pready;
	assign bitop   = qio_bitop_t'(pwdata[`QIO_BITOP_OP_LO +: 2]);
	assign bitport = pwdata[`QIO_BITOP_PORT_LO +: 2];
	assign bitsel  = pwdata[`QIO_BITOP_SEL_LO +: 3];

	always_comb
	begin
		mapped    = 1'b1;
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			`QIO_OFS_LAT0:   rdata_nxt[W-1:0] = latch_r[0];
			`QIO_OFS_LAT1:   rdata_nxt[W-1:0] = latch_r[1];
			`QIO_OFS_LAT2:   rdata_nxt[W-1:0] = latch_r[2];
			`QIO_OFS_LAT3:   rdata_nxt[W-1:0] = latch_r[3];
			`QIO_OFS_PIN0:   rdata_nxt[W-1:0] = pin_r[0];
			`QIO_OFS_PIN1:   rdata_nxt[W-1:0] = pin_r[1];
			`QIO_OFS_PIN2:   rdata_nxt[W-1:0] = pin_r[2];
			`QIO_OFS_PIN3:   rdata_nxt[W-1:0] = pin_r[3];
			`QIO_OFS_BITOP:  rdata_nxt = 32'h0000_0000;
			`QIO_OFS_STATUS:
			begin
				rdata_nxt[`QIO_STAT_EXT_BIT] = ext_active;
				rdata_nxt[`QIO_STAT_ST_LO +: 3] = state_r;
			end
			default:         mapped = 1'b0;
		endcase
	end

	// zero wait states: pready rises the cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite && mapped)
				prdata <= rdata_nxt;
			else if (setup)
				prdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// port latches

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NPORT; p++)
				latch_r[p] <= `QIO_LATCH_RST;
		end
		else
		begin
			if (access && pwrite && !pslverr)
			begin
				case (paddr)
					`QIO_OFS_LAT0:  latch_r[0] <= pwdata[W-1:0];
					`QIO_OFS_LAT1:  latch_r[1] <= pwdata[W-1:0];
					`QIO_OFS_LAT2:  latch_r[2] <= pwdata[W-1:0];
					`QIO_OFS_LAT3:  latch_r[3] <= pwdata[W-1:0];
					`QIO_OFS_BITOP:
						latch_r[bitport] <= rmw_bit(latch_r[bitport],
							bitsel, bitop);
					default: ;
				endcase
			end
			// the bus access wins over any software write to port zero
			if (ext_active)
				latch_r[0] <= `QIO_LATCH_RST;
		end
	end

	////////////////////////////////////////////////////////////////////
	// output buffers sample the latches only at the start of a cycle;
	// a write landing mid-cycle waits, which keeps pin timing fixed

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NPORT; p++)
				buf_r[p] <= `QIO_LATCH_RST;
		end
		else if (s1p1)
		begin
			for (int p = 0; p < NPORT; p++)
				buf_r[p] <= latch_r[p];
		end
	end

	assign p0_bus = ext_active;
	assign p2_bus = ext_active && ext_wide;

	// effective level before the drivers; alternate output gated by latch
	always_comb
	begin
		eff_nxt[0] = buf_r[0];
		eff_nxt[1] = buf_r[1];
		eff_nxt[2] = p2_bus ? ext_addr[15:8] : buf_r[2];
		eff_nxt[3] = buf_r[3] & alt_out;
		if (p0_bus)
		begin
			if (ext_phase == QIO_BUS_WDATA)
				eff_nxt[0] = ext_wdata;
			else
				eff_nxt[0] = ext_addr[7:0];
		end
	end

	// registered output mux, refreshed every phase 1
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NPORT; p++)
			begin
				eff_r[p] <= `QIO_LATCH_RST;
				spu_r[p] <= 8'h00;
			end
		end
		else if (ph1)
		begin
			for (int p = 0; p < NPORT; p++)
			begin
				eff_r[p] <= eff_nxt[p];
				// rising bits get the boost for the whole state
				spu_r[p] <= eff_nxt[p] & ~eff_r[p];
			end
			if (p2_bus)
				spu_r[2] <= eff_nxt[2];
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin drivers: oe & ~o is the pull-down, oe & o a pull-up

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NPORT; p++)
			begin
				drv_o_r[p]  <= 8'h00;
				drv_oe_r[p] <= 8'h00;
			end
		end
		else
		begin
			// port zero: push-pull on the bus, released in the float phase, open drain otherwise
			if (p0_bus && ext_phase == QIO_BUS_FLOAT)
			begin
				drv_o_r[0]  <= 8'h00;
				drv_oe_r[0] <= 8'h00;
			end
			else if (p0_bus)
			begin
				drv_o_r[0]  <= eff_r[0];
				drv_oe_r[0] <= 8'hff;
			end
			else
			begin
				drv_o_r[0]  <= 8'h00;
				drv_oe_r[0] <= ~eff_r[0];
			end
			// ports one to three: weak pull-up is outside, strong one here
			for (int p = 1; p < NPORT; p++)
			begin
				drv_o_r[p]  <= eff_r[p];
				drv_oe_r[p] <= quasi_oe(eff_r[p], spu_r[p]);
			end
		end
	end

	assign p0_o  = drv_o_r[0];
	assign p0_oe = drv_oe_r[0];
	assign p1_o  = drv_o_r[1];
	assign p1_oe = drv_oe_r[1];
	assign p2_o  = drv_o_r[2];
	assign p2_oe = drv_oe_r[2];
	assign p3_o  = drv_o_r[3];
	assign p3_oe = drv_oe_r[3];

endmodule

`default_nettype wire

// ---- verilog/qio_cfg.svh ----
// constants for the quasi-bidirectional port block
`ifndef QIO_CFG_SVH
`define QIO_CFG_SVH

// register byte offsets on the register bus
`define QIO_OFS_LAT0    8'h00
`define QIO_OFS_LAT1    8'h04
`define QIO_OFS_LAT2    8'h08
`define QIO_OFS_LAT3    8'h0c
`define QIO_OFS_PIN0    8'h10
`define QIO_OFS_PIN1    8'h14
`define QIO_OFS_PIN2    8'h18
`define QIO_OFS_PIN3    8'h1c
`define QIO_OFS_BITOP   8'h20
`define QIO_OFS_STATUS  8'h24

// bit-operation register fields
`define QIO_BITOP_SEL_LO  0
`define QIO_BITOP_PORT_LO 3
`define QIO_BITOP_OP_LO   5

// status register fields
`define QIO_STAT_EXT_BIT  0
`define QIO_STAT_ST_LO    1

// every port latch comes out of reset at all ones
`define QIO_LATCH_RST   8'hff

// timing in oscillator periods (one pclk period each)
`define QIO_STATE_OSC   2
`define QIO_SPU_OSC     2

`endif

// ---- verilog/qio_pkg.sv ----
// types shared by the quasi-bidirectional port block
package qio_pkg;

	// machine-cycle states, gray coded along the S1..S6 walk
	typedef enum logic [2:0]
	{
		QIO_S1 = 3'h0,
		QIO_S2 = 3'h1,
		QIO_S3 = 3'h3,
		QIO_S4 = 3'h2,
		QIO_S5 = 3'h6,
		QIO_S6 = 3'h7
	} qio_state_t;

	// what port zero carries during an external access
	typedef enum logic [1:0]
	{
		QIO_BUS_ADDR  = 2'h0,
		QIO_BUS_WDATA = 2'h1,
		QIO_BUS_FLOAT = 2'h2
	} qio_bus_phase_t;

	// read-modify-write bit operations
	typedef enum logic [1:0]
	{
		QIO_OP_NONE  = 2'h0,
		QIO_OP_SET   = 2'h1,
		QIO_OP_CLEAR = 2'h2,
		QIO_OP_CPL   = 2'h3
	} qio_bitop_t;

endpackage

// ---- tb/qio_ports_properties.sv ----
// concurrent checks on the port block's bus and pins
`timescale 1ns/1ns
`default_nettype none

module qio_ports_checker
	import qio_pkg::*;
(
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic [7:0]              paddr,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    ext_active,
	input wire logic                    ext_wide,
	input wire logic [15:0]             ext_addr,
	input wire qio_pkg::qio_bus_phase_t ext_phase,
	input wire logic                    ext_rd_sample,
	input wire logic [7:0]              ext_rdata,
	input wire logic                    cycle_start,
	input wire logic                    rxd_in,
	input wire logic                    ext_irq_zero_n,
	input wire logic [7:0]              p0_i,
	input wire logic [7:0]              p0_o,
	input wire logic [7:0]              p0_oe,
	input wire logic [7:0]              p1_o,
	input wire logic [7:0]              p1_oe,
	input wire logic [7:0]              p2_o,
	input wire logic [7:0]              p2_oe,
	input wire logic [7:0]              p3_i
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence

	// strong pull-up: two clocks driven high, then released
	sequence s_spu;
		(|(p1_oe & p1_o))[*2] ##1 !(|(p1_oe & p1_o));
	endsequence

	a_ready_next: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	a_ready_access: assert property (pready |-> psel && penable && !$past(penable))
		else $error("ready outside access");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h24 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_machine_cycle: assert property (cycle_start |=> !cycle_start ##11 cycle_start)
		else $error("machine cycle not twelve clocks");
	a_p0_addr_drive: assert property ((ext_active && ext_phase == QIO_BUS_ADDR && $stable(ext_addr))[*6] |-> p0_oe == 8'hff && p0_o == ext_addr[7:0])
		else $error("low address not on port zero");
	a_p2_high_addr: assert property ((ext_active && ext_wide && $stable(ext_addr))[*6] |-> p2_oe == 8'hff && p2_o == ext_addr[15:8])
		else $error("high address not on port two");
	a_p0_float: assert property ((ext_active && ext_phase == QIO_BUS_FLOAT)[*6] |-> p0_oe == 8'h00)
		else $error("port zero driven while floating");
	a_p0_open_drain: assert property ((!ext_active)[*6] |-> !(|(p0_o & p0_oe)))
		else $error("port zero pulled up outside bus");
	a_spu_pulse: assert property ($rose(|(p1_oe & p1_o)) |-> s_spu)
		else $error("strong pull-up not two clocks");
	a_alt_input: assert property ($stable(p3_i)[*8] |-> rxd_in == p3_i[0] && ext_irq_zero_n == p3_i[2])
		else $error("alternate input not following pin");
	a_rd_capture: assert property ((ext_active && ext_rd_sample && $stable(p0_i))[*8] |-> ext_rdata == p0_i)
		else $error("read byte not taken from pins");
endmodule

bind qio_ports qio_ports_checker u_chk
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_active(ext_active), .ext_wide(ext_wide), .ext_addr(ext_addr),
	.ext_phase(ext_phase), .ext_rd_sample(ext_rd_sample),
	.ext_rdata(ext_rdata), .cycle_start(cycle_start), .rxd_in(rxd_in),
	.ext_irq_zero_n(ext_irq_zero_n), .p0_i(p0_i), .p0_o(p0_o),
	.p0_oe(p0_oe), .p1_o(p1_o), .p1_oe(p1_oe), .p2_o(p2_o),
	.p2_oe(p2_oe), .p3_i(p3_i)
);

`default_nettype wire

// ---- tb/qio_pin_model.sv ----
// external devices and memory seen at the four ports' pins
`timescale 1ns/1ns
`default_nettype none

module qio_pin_model
(
	input  wire logic [7:0] p0_o,
	input  wire logic [7:0] p0_oe,
	input  wire logic [7:0] p1_o,
	input  wire logic [7:0] p1_oe,
	input  wire logic [7:0] p2_o,
	input  wire logic [7:0] p2_oe,
	input  wire logic [7:0] p3_o,
	input  wire logic [7:0] p3_oe,
	input  wire logic       pclk,
	input  wire logic       mem_en,
	input  wire logic [7:0] mem_data,
	input  wire logic [7:0] lo1,
	input  wire logic [7:0] lo2,
	input  wire logic [7:0] lo3,
	output var  logic [7:0] p0_i,
	output var  logic [7:0] p1_i,
	output var  logic [7:0] p2_i,
	output var  logic [7:0] p3_i
);
	logic [7:0] wander;

	initial wander = 8'h55;
	// port zero has no pull-up: a released line must not look settled
	always @(posedge pclk) wander <= ~wander;

	assign p0_i = (p0_oe & p0_o) | (~p0_oe & (mem_en ? mem_data : wander));
	// weak pull-up holds released pins high unless a device sinks them
	assign p1_i = (p1_oe & p1_o) | (~p1_oe & ~lo1);
	assign p2_i = (p2_oe & p2_o) | (~p2_oe & ~lo2);
	assign p3_i = (p3_oe & p3_o) | (~p3_oe & ~lo3);
endmodule

`default_nettype wire

// ---- tb/qio_ports_bench.sv ----
// self-checking bench for the quasi-bidirectional port block
`timescale 1ns/1ns
`include "qio_cfg.svh"
`default_nettype none

module qio_ports_bench;
	import qio_pkg::*;

	logic                   pclk, presetn, psel, penable, pwrite;
	logic [7:0]             paddr, ext_wdata, ext_rdata, alt_out;
	logic [31:0]            pwdata, prdata, rd;
	logic                   pready, pslverr, err, ext_active, ext_wide;
	logic [15:0]            ext_addr;
	qio_bus_phase_t         ext_phase;
	logic                   ext_rd_sample, rxd_in, irq0_n, irq1_n;
	logic                   cnt0, cnt1, cycle_start, mem_en;
	logic [7:0]             p0_i, p1_i, p2_i, p3_i, p0_o, p1_o, p2_o, p3_o;
	logic [7:0]             p0_oe, p1_oe, p2_oe, p3_oe;
	logic [7:0]             mem_data, lo1, lo2, lo3;
	int                     n_fail, comparisons;

	qio_ports u_dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_active(ext_active),
		.ext_wide(ext_wide), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
		.ext_phase(ext_phase), .ext_rd_sample(ext_rd_sample),
		.ext_rdata(ext_rdata), .alt_out(alt_out), .rxd_in(rxd_in),
		.ext_irq_zero_n(irq0_n), .ext_irq_one_n(irq1_n),
		.counter_zero_ext_input(cnt0), .counter_one_ext_input(cnt1),
		.cycle_start(cycle_start), .p0_i(p0_i), .p0_o(p0_o),
		.p0_oe(p0_oe), .p1_i(p1_i), .p1_o(p1_o), .p1_oe(p1_oe),
		.p2_i(p2_i), .p2_o(p2_o), .p2_oe(p2_oe), .p3_i(p3_i),
		.p3_o(p3_o), .p3_oe(p3_oe)
	);

	qio_pin_model u_pins
	(
		.p0_o(p0_o), .p0_oe(p0_oe), .p1_o(p1_o), .p1_oe(p1_oe),
		.p2_o(p2_o), .p2_oe(p2_oe), .p3_o(p3_o), .p3_oe(p3_oe),
		.pclk(pclk), .mem_en(mem_en), .mem_data(mem_data), .lo1(lo1),
		.lo2(lo2), .lo3(lo3), .p0_i(p0_i), .p1_i(p1_i), .p2_i(p2_i),
		.p3_i(p3_i)
	);

	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// latch writes reach the pins only at a machine-cycle start, so wait for one first
	task automatic settle();
		for (int i = 0; i < 16 && cycle_start !== 1'b1; i++)
			@(posedge pclk);
		repeat (10) @(posedge pclk);
	endtask

	task automatic t_reset();
		chk(p0_oe, 8'h00);
		chk(p1_oe, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, 32'hff);
		end
		$display("test reset done");
	endtask

	task automatic t_latch();
		settle();
		apb(1'b1, `QIO_OFS_LAT1, 32'h5a);
		chk(p1_oe, 8'h00);
		apb(1'b0, `QIO_OFS_LAT1, 32'h0);
		chk(rd, 32'h5a);
		settle();
		chk(p1_oe, 8'ha5);
		apb(1'b0, `QIO_OFS_PIN1, 32'h0);
		chk(rd, 32'h5a);
		apb(1'b1, `QIO_OFS_LAT1, 32'hff);
		lo1 <= 8'h81;
		settle();
		chk(p1_oe, 8'h00);
		apb(1'b0, `QIO_OFS_PIN1, 32'h0);
		chk(rd, 32'h7e);
		apb(1'b0, `QIO_OFS_LAT1, 32'h0);
		chk(rd, 32'hff);
		lo1 <= 8'h00;
		$display("test latch done");
	endtask

	task automatic t_bitop();
		qio_bitop_t op_l [3] = '{QIO_OP_SET, QIO_OP_CLEAR, QIO_OP_CPL};
		logic [2:0] bit_l [3] = '{3'd7, 3'd0, 3'd1};
		logic [7:0] exp_l [3] = '{8'h8f, 8'h8e, 8'h8c};
		apb(1'b1, `QIO_OFS_LAT2, 32'h0f);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, `QIO_OFS_BITOP, {25'h0, op_l[i], 2'd2, bit_l[i]});
			apb(1'b0, `QIO_OFS_LAT2, 32'h0);
			chk(rd, {24'h0, exp_l[i]});
		end
		apb(1'b0, `QIO_OFS_BITOP, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({err, rd}, 33'h1_0000_0000);
		$display("test bitop done");
	endtask

	task automatic t_alt();
		apb(1'b1, `QIO_OFS_LAT3, 32'h7f);
		alt_out <= 8'h3d;
		settle();
		chk(p3_oe, 8'hc2);
		chk(p3_o, 8'h3d);
		alt_out <= 8'hff;
		lo3 <= 8'h0d;
		settle();
		chk(p3_oe, 8'h80);
		chk({rxd_in, irq0_n, irq1_n}, 3'b000);
		lo3 <= 8'h30;
		settle();
		chk({cnt0, cnt1, rxd_in}, 3'b001);
		lo3 <= 8'h00;
		$display("test alternate done");
	endtask

	task automatic t_ext();
		apb(1'b1, `QIO_OFS_LAT0, 32'h00);
		apb(1'b1, `QIO_OFS_LAT2, 32'h3c);
		ext_addr <= 16'h12b4;
		ext_active <= 1'b1;
		settle();
		chk({p0_oe, p0_o}, 16'hffb4);
		chk(p2_oe, 8'hc3);
		apb(1'b1, `QIO_OFS_LAT0, 32'h00);
		apb(1'b0, `QIO_OFS_LAT0, 32'h0);
		chk(rd, 32'hff);
		apb(1'b0, `QIO_OFS_STATUS, 32'h0);
		chk(rd[0], 1'b1);
		ext_wide <= 1'b1;
		ext_phase <= QIO_BUS_WDATA;
		ext_wdata <= 8'hc9;
		settle();
		chk({p2_oe, p2_o}, 16'hff12);
		chk(p0_o, 8'hc9);
		ext_phase <= QIO_BUS_FLOAT;
		mem_en <= 1'b1;
		mem_data <= 8'ha7;
		ext_rd_sample <= 1'b1;
		settle();
		chk({p0_oe, ext_rdata}, 16'h00a7);
		ext_rd_sample <= 1'b0;
		mem_en <= 1'b0;
		ext_active <= 1'b0;
		ext_wide <= 1'b0;
		ext_phase <= QIO_BUS_ADDR;
		settle();
		chk({p2_oe, p0_oe}, 16'hc300);
		apb(1'b0, `QIO_OFS_LAT2, 32'h0);
		chk(rd, 32'h3c);
		$display("test external done");
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// whole run is a few hundred clocks; the ceiling leaves ample margin
	initial
	begin
		for (int i = 0; i < 20000; i++)
			@(posedge pclk);
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, ext_active, ext_wide} = 6'h0;
		{ext_rd_sample, mem_en, paddr, pwdata} = 42'h0;
		{ext_addr, ext_wdata, mem_data, lo1, lo2, lo3} = 56'h0;
		ext_phase = QIO_BUS_ADDR;
		alt_out = 8'hff;
		n_fail = 0;
		comparisons = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_latch();
		t_bitop();
		t_alt();
		t_ext();
		tally_and_finish();
	end
endmodule

`default_nettype wire
